// ==== logic/fops_cfg.svh ====
`ifndef FOPS_CFG_SVH
`define FOPS_CFG_SVH

`define FOPS_OFS_OPTION 8'h00
`define FOPS_OFS_CONFIG 8'h04
`define FOPS_OFS_PROTECT 8'h08
`define FOPS_OFS_STATUS 8'h0c
`define FOPS_OFS_DIVIDER 8'h10
`define FOPS_OFS_COMMAND 8'h14

`define FOPS_OPT_BACKDOOR_ENABLE_BIT 7
`define FOPS_OPT_NORED_BIT 6
`define FOPS_OPT_USED_MASK 8'hc3
`define FOPS_SEC_UNSECURED 2'h2
`define FOPS_CFG_RW_MASK 8'he0
`define FOPS_CFG_KEY_ACCESS_ENABLE_BIT 5
`define FOPS_PROT_DIS_BIT 0
`define FOPS_STAT_CBEF_BIT 7
`define FOPS_STAT_CCF_BIT 6
`define FOPS_STAT_PVIOL_BIT 5
`define FOPS_STAT_ACCERR_BIT 4
`define FOPS_STAT_BLANK_BIT 2
`define FOPS_DIV_LOADED_BIT 7

`define FOPS_RST_BYTE 8'h00
`define FOPS_RST_STATUS 8'hc0

`define FOPS_CMD_BLANK 8'h05
`define FOPS_CMD_BYTE_PROG 8'h20
`define FOPS_CMD_BURST_PROG 8'h25
`define FOPS_CMD_PAGE_ERASE 8'h40
`define FOPS_CMD_MASS_ERASE 8'h41

`define FOPS_KEY_BASE 16'hffb0
`define FOPS_KEY_BYTES 8
`define FOPS_PAGE_SHIFT 9

`endif

// ==== logic/fops_pkg.sv ====
package fops_pkg;

  typedef enum logic [2:0] {
    FOPS_SEQ_IDLE = 3'b001,
    FOPS_SEQ_DATA = 3'b010,
    FOPS_SEQ_CMD = 3'b100
  } fops_seq_t;

  typedef struct packed {
    logic valid;
    logic debug;
    logic [15:0] addr;
    logic [7:0] data;
  } fops_fwr_t;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } fops_cmd_t;

endpackage : fops_pkg

// ==== logic/fops_ctrl.sv ====
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "fops_cfg.svh"

// What this block does
// [R1] Option register loaded from flash each reset
// [R2] Option unused bits zero, writes ignored
// [R3] Backdoor unlock refused while backdoor disabled
// [R4] Ordered eight-byte firmware key match unsecures
// [R5] Option bit six disables vector redirection
// [R6] Only security code 1:0 means unsecured
// [R7] Secure blocks memory access from unsecured sources
// [R8] Key match or full blank forces 1:0
// [R9] Config bits 7..5 read/write, rest zero
// [R10] Key-access bit steers window writes
// [R11] Protection loaded at reset, always readable
// [R12] Application may only enlarge protection
// [R13] Select field bounds protected top region
// [R14] Debug path may rewrite protection freely
// [R15] Status bits 3,1,0 read zero
// [R16] Writing one to buffer-empty launches command
// [R17] Complete flag set when empty and idle
// [R18] Protected target sets violation, discards command
// [R19] Sequence, divider, stop faults set access error
// [R20] Blank flag set by clean blank check
// [R21] Five legal command codes, others error
// [R22] Divider loaded flag gates erase/program
// [R23] Registers are bytes on the processor bus
module fops_ctrl
  import fops_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [7:0] nonvolatile_protection_byte,
  input wire logic [63:0] backdoor_key_bytes,
  input wire fops_fwr_t flash_write,
  input wire logic dbg_prot_valid,
  input wire logic [7:0] dbg_prot_data,
  input wire logic mem_req_unsecured,
  input wire logic stop_entry,
  input wire logic engine_done,
  input wire logic engine_blank_ok,
  output logic mem_access_blocked,
  output logic vector_redirect_disable,
  output logic secure_state,
  output logic cmd_start,
  output fops_cmd_t cmd_out,
  output logic [6:0] divider_value
);

  logic addr_wr_reg, addr_wr_next;
  logic [7:0] addr_ofs_reg, addr_ofs_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic load_reg, load_next;
  logic [7:0] opt_reg, opt_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] prot_reg, prot_next;
  logic [7:0] div_reg, div_next;
  logic cbef_reg, cbef_next;
  logic pviol_reg, pviol_next;
  logic accerr_reg, accerr_next;
  logic blank_reg, blank_next;
  logic busy_reg, busy_next;
  logic pend_reg, pend_next;
  fops_seq_t seq_reg, seq_next;
  fops_cmd_t cmd_reg, cmd_next;
  logic start_reg, start_next;
  logic [3:0] key_cnt_reg, key_cnt_next;
  logic key_ok_reg, key_ok_next;
  logic blocked_reg, blocked_next;
  logic secure_reg, secure_next;

  logic wr_en;
  logic [7:0] wd;
  logic ccf;
  logic hresetn_q;

  function automatic logic is_secure(input logic [1:0] code);
    return code != `FOPS_SEC_UNSECURED;
  endfunction : is_secure

  function automatic logic is_legal(input logic [7:0] code);
    return code == `FOPS_CMD_BLANK || code == `FOPS_CMD_BYTE_PROG ||
           code == `FOPS_CMD_BURST_PROG || code == `FOPS_CMD_PAGE_ERASE ||
           code == `FOPS_CMD_MASS_ERASE;
  endfunction : is_legal

  // Blank check only reads, so it can never hit a protected block.
  function automatic logic hits_protect(input logic [7:0] prot,
                                        input fops_cmd_t cmd);
    if (prot[`FOPS_PROT_DIS_BIT] || cmd.code == `FOPS_CMD_BLANK) begin
      return 1'b0;
    end
    if (cmd.code == `FOPS_CMD_MASS_ERASE) begin
      return 1'b1;
    end
    return cmd.addr[15:`FOPS_PAGE_SHIFT] > prot[7:1];
  endfunction : hits_protect

  // Command complete is derived so it can never disagree with its causes.
  assign ccf = cbef_reg && !busy_reg && !pend_reg; // [R17]
  assign wr_en = addr_wr_reg;
  assign wd = hwdata[7:0];

  always_comb begin
    logic launch;
    logic is_key;
    launch = 1'b0;
    is_key = 1'b0;
    addr_wr_next = 1'b0;
    addr_ofs_next = addr_ofs_reg;
    hrdata_next = hrdata_reg;
    load_next = 1'b0;
    opt_next = opt_reg;
    cfg_next = cfg_reg;
    prot_next = prot_reg;
    div_next = div_reg;
    cbef_next = cbef_reg;
    pviol_next = pviol_reg;
    accerr_next = accerr_reg;
    blank_next = blank_reg;
    busy_next = busy_reg;
    pend_next = pend_reg;
    seq_next = seq_reg;
    cmd_next = cmd_reg;
    start_next = 1'b0;
    key_cnt_next = key_cnt_reg;
    key_ok_next = key_ok_reg;
    blocked_next = is_secure(opt_reg[1:0]) && mem_req_unsecured; // [R7]
    if (load_reg) begin
      opt_next = nonvolatile_option_byte & `FOPS_OPT_USED_MASK; // [R1] [R2]
      prot_next = nonvolatile_protection_byte; // [R11]
    end
    // Reads are sampled in the address phase so hrdata comes from a flop.
    if (hsel && hready && htrans[1]) begin
      addr_wr_next = hwrite;
      addr_ofs_next = haddr;
      if (!hwrite) begin
        unique case (haddr)
          `FOPS_OFS_OPTION: hrdata_next = {24'h000000, opt_reg}; // [R2]
          `FOPS_OFS_CONFIG: hrdata_next = {24'h000000, cfg_reg}; // [R9]
          `FOPS_OFS_PROTECT: hrdata_next = {24'h000000, prot_reg}; // [R11]
          `FOPS_OFS_STATUS: hrdata_next = {24'h000000, cbef_reg, ccf,
            pviol_reg, accerr_reg, 1'b0, blank_reg, 2'h0}; // [R15]
          `FOPS_OFS_DIVIDER: hrdata_next = {24'h000000, div_reg};
          default: hrdata_next = 32'h00000000;
        endcase
      end
    end
    // Option register has no bus write path; only key unlock and a blank pass change bits 1:0. [R2]
    if (wr_en && addr_ofs_reg == `FOPS_OFS_CONFIG) begin
      if (!wd[`FOPS_CFG_KEY_ACCESS_ENABLE_BIT] && cfg_reg[`FOPS_CFG_KEY_ACCESS_ENABLE_BIT]) begin
        if (opt_reg[`FOPS_OPT_BACKDOOR_ENABLE_BIT] && key_ok_reg && // [R3]
            key_cnt_reg == 4'(`FOPS_KEY_BYTES)) begin
          opt_next[1:0] = `FOPS_SEC_UNSECURED; // [R4] [R8]
        end
      end
      if (wd[`FOPS_CFG_KEY_ACCESS_ENABLE_BIT] && !cfg_reg[`FOPS_CFG_KEY_ACCESS_ENABLE_BIT]) begin
        key_cnt_next = 4'h0;
        key_ok_next = 1'b1;
      end
      cfg_next = wd & `FOPS_CFG_RW_MASK; // [R9]
    end
    if (wr_en && addr_ofs_reg == `FOPS_OFS_PROTECT &&
        !prot_reg[`FOPS_PROT_DIS_BIT] && !wd[`FOPS_PROT_DIS_BIT] &&
        wd[7:1] < prot_reg[7:1]) begin
      prot_next = wd; // [R12]
    end
    if (dbg_prot_valid) begin
      prot_next = dbg_prot_data; // [R14]
    end
    if (wr_en && addr_ofs_reg == `FOPS_OFS_DIVIDER &&
        !div_reg[`FOPS_DIV_LOADED_BIT]) begin
      div_next = {1'b1, wd[6:0]}; // [R22]
    end
    if (flash_write.valid && cfg_reg[`FOPS_CFG_KEY_ACCESS_ENABLE_BIT]) begin
      is_key = 1'b1;
      // Debug writes and out-of-order bytes spoil the key attempt.
      if (flash_write.debug || key_cnt_reg >= 4'(`FOPS_KEY_BYTES) ||
          flash_write.addr != `FOPS_KEY_BASE + 16'(key_cnt_reg) ||
          flash_write.data != backdoor_key_bytes[63 - 8*key_cnt_reg -: 8]) begin
        key_ok_next = 1'b0; // [R4]
      end
      if (key_cnt_reg < 4'(`FOPS_KEY_BYTES)) begin
        key_cnt_next = key_cnt_reg + 4'h1; // [R10]
      end
    end
    // Flag clears come first so that a same-cycle set below wins.
    if (wr_en && addr_ofs_reg == `FOPS_OFS_STATUS) begin
      if (wd[`FOPS_STAT_PVIOL_BIT]) begin
        pviol_next = 1'b0; // [R18]
      end
      if (wd[`FOPS_STAT_ACCERR_BIT]) begin
        accerr_next = 1'b0; // [R19]
      end
    end
    unique case (seq_reg)
      FOPS_SEQ_IDLE: begin
        if (flash_write.valid && !is_key) begin
          if (!div_reg[`FOPS_DIV_LOADED_BIT] || !cbef_reg) begin
            accerr_next = 1'b1; // [R19] [R22]
          end else begin
            cmd_next.addr = flash_write.addr; // [R10]
            cmd_next.data = flash_write.data;
            seq_next = FOPS_SEQ_DATA;
          end
        end else if (wr_en && (addr_ofs_reg == `FOPS_OFS_COMMAND ||
                   (addr_ofs_reg == `FOPS_OFS_STATUS &&
                    wd[`FOPS_STAT_CBEF_BIT]))) begin
          accerr_next = 1'b1; // [R19]
        end
      end
      FOPS_SEQ_DATA: begin
        if (wr_en && addr_ofs_reg == `FOPS_OFS_COMMAND) begin
          if (is_legal(wd)) begin
            cmd_next.code = wd;
            seq_next = FOPS_SEQ_CMD;
          end else begin
            accerr_next = 1'b1; // [R21]
            seq_next = FOPS_SEQ_IDLE;
          end
        end else if ((flash_write.valid && !is_key) || (wr_en &&
                   addr_ofs_reg == `FOPS_OFS_STATUS &&
                   wd[`FOPS_STAT_CBEF_BIT])) begin
          accerr_next = 1'b1; // [R19]
          seq_next = FOPS_SEQ_IDLE;
        end
      end
      FOPS_SEQ_CMD: begin
        if (wr_en && addr_ofs_reg == `FOPS_OFS_STATUS &&
            wd[`FOPS_STAT_CBEF_BIT]) begin
          seq_next = FOPS_SEQ_IDLE;
          if (hits_protect(prot_reg, cmd_reg)) begin
            pviol_next = 1'b1; // [R13] [R18]
          end else begin
            launch = 1'b1; // [R16]
          end
        end else if ((flash_write.valid && !is_key) ||
                     (wr_en && addr_ofs_reg == `FOPS_OFS_COMMAND)) begin
          accerr_next = 1'b1; // [R19]
          seq_next = FOPS_SEQ_IDLE;
        end
      end
    endcase
    if (engine_done) begin
      busy_next = 1'b0;
      if (cmd_reg.code == `FOPS_CMD_BLANK && engine_blank_ok) begin
        blank_next = 1'b1; // [R20]
        opt_next[1:0] = `FOPS_SEC_UNSECURED; // [R8]
      end
    end
    if (stop_entry && (busy_reg || pend_reg)) begin
      accerr_next = 1'b1; // [R19]
      busy_next = 1'b0;
      pend_next = 1'b0;
      cbef_next = 1'b1;
    end else begin
      if (launch) begin
        cbef_next = 1'b0; // [R16]
        blank_next = 1'b0; // [R20]
        pend_next = 1'b1;
      end
      // A queued burst byte moves into the array once the engine is free.
      if (pend_reg && (!busy_reg || engine_done)) begin
        pend_next = launch;
        busy_next = 1'b1;
        start_next = 1'b1;
        cbef_next = 1'b1; // [R16]
      end
    end
    if (!cbef_next && !pend_next) begin
      cbef_next = 1'b1;
    end
    secure_next = is_secure(opt_next[1:0]); // [R6]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_wr_reg <= 1'b0;
      addr_ofs_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      load_reg <= 1'b1;
      opt_reg <= `FOPS_RST_BYTE;
      cfg_reg <= `FOPS_RST_BYTE;
      prot_reg <= `FOPS_RST_BYTE;
      div_reg <= `FOPS_RST_BYTE;
      cbef_reg <= 1'b1;
      pviol_reg <= 1'b0;
      accerr_reg <= 1'b0;
      blank_reg <= 1'b0;
      busy_reg <= 1'b0;
      pend_reg <= 1'b0;
      seq_reg <= FOPS_SEQ_IDLE;
      cmd_reg <= '0;
      start_reg <= 1'b0;
      key_cnt_reg <= 4'h0;
      key_ok_reg <= 1'b0;
      blocked_reg <= 1'b0;
      secure_reg <= 1'b0;
    end else begin
      addr_wr_reg <= addr_wr_next;
      addr_ofs_reg <= addr_ofs_next;
      hrdata_reg <= hrdata_next;
      load_reg <= load_next;
      opt_reg <= opt_next;
      cfg_reg <= cfg_next;
      prot_reg <= prot_next;
      div_reg <= div_next;
      cbef_reg <= cbef_next;
      pviol_reg <= pviol_next;
      accerr_reg <= accerr_next;
      blank_reg <= blank_next;
      busy_reg <= busy_next;
      pend_reg <= pend_next;
      seq_reg <= seq_next;
      cmd_reg <= cmd_next;
      start_reg <= start_next;
      key_cnt_reg <= key_cnt_next;
      key_ok_reg <= key_ok_next;
      blocked_reg <= blocked_next;
      secure_reg <= secure_next;
    end
  end

  // Zero-wait slave: every transfer completes OKAY in its first data cycle.
  assign hrdata = hrdata_reg; // [R23]
  assign hreadyout = hresetn_q;
  assign hresp = 1'b0;
  assign mem_access_blocked = blocked_reg;
  assign vector_redirect_disable = opt_reg[`FOPS_OPT_NORED_BIT]; // [R5]
  assign secure_state = secure_reg; // [R6]
  assign cmd_start = start_reg;
  assign cmd_out = cmd_reg;
  assign divider_value = div_reg[6:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresetn_q <= 1'b1;
    end else begin
      hresetn_q <= 1'b1;
    end
  end

  a_opt_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_ofs_reg == `FOPS_OFS_OPTION && !load_reg &&
     !engine_done && seq_reg == FOPS_SEQ_IDLE && !cfg_reg[5])
    |=> $stable(opt_reg)) else $error("option register changed by write"); // [R2]

  a_opt_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    opt_reg[5:2] == 4'h0) else $error("option unused bits not zero"); // [R2]

  a_opt_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
    load_reg |=> opt_reg == ($past(nonvolatile_option_byte) & 8'hc3))
    else $error("option not loaded after reset"); // [R1]

  a_cfg_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_reg[4:0] == 5'h00) else $error("config low bits not zero"); // [R9]

  a_prot_only_grow: assert property (@(posedge hclk) disable iff (!hresetn)
    (!load_reg && !dbg_prot_valid && $past(!dbg_prot_valid) &&
     !$past(load_reg)) |-> (prot_reg[7:1] <= $past(prot_reg[7:1])))
    else $error("protection reduced by software"); // [R12]

  a_ccf_launch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_reg == FOPS_SEQ_CMD && wr_en && addr_ofs_reg == `FOPS_OFS_STATUS &&
     wd[7] && !hits_protect(prot_reg, cmd_reg) && !stop_entry)
    |=> !ccf ##1 cmd_start) else $error("launch did not start command"); // [R16]

  a_pviol_discard: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_reg == FOPS_SEQ_CMD && wr_en && addr_ofs_reg == `FOPS_OFS_STATUS &&
     wd[7] && hits_protect(prot_reg, cmd_reg))
    |=> pviol_reg ##1 !cmd_start) else $error("violation not flagged"); // [R18]

  a_div_gates_prog: assert property (@(posedge hclk) disable iff (!hresetn)
    (flash_write.valid && !cfg_reg[5] && !div_reg[7] &&
     seq_reg == FOPS_SEQ_IDLE) |=> accerr_reg && seq_reg == FOPS_SEQ_IDLE)
    else $error("program before divider not refused"); // [R22]

  a_illegal_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_reg == FOPS_SEQ_DATA && wr_en && addr_ofs_reg == `FOPS_OFS_COMMAND &&
     !is_legal(wd)) |=> accerr_reg) else $error("bad code accepted"); // [R21]

  a_blank_unsecure: assert property (@(posedge hclk) disable iff (!hresetn)
    (engine_done && engine_blank_ok && cmd_reg.code == 8'h05 && !load_reg)
    |=> blank_reg && !secure_state) else $error("blank pass ignored"); // [R8]

  a_block_secure: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_req_unsecured && secure_state && !load_reg) |=> mem_access_blocked)
    else $error("unsecured access not blocked"); // [R7]

endmodule : fops_ctrl

// ==== sim/test_fops_ctrl.sv ====
`timescale 1ns/1ps
`include "fops_cfg.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  fails++; $display("unexpected %s expected %h seen %h", nm, ex, got); \
  end end

module test_fops_ctrl
  import fops_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0] nv_opt, nv_prot, dbg_prot_data;
  logic [63:0] key;
  fops_fwr_t flash_write;
  logic dbg_prot_valid, mem_req_unsecured, stop_entry;
  logic engine_done, engine_blank_ok, mem_access_blocked;
  logic vector_redirect_disable, secure_state, cmd_start;
  fops_cmd_t cmd_out, last_cmd;
  logic [6:0] divider_value;
  logic [7:0] codes [5];
  int fails, n_compared, n_start, cycles, s0;

  fops_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .nonvolatile_option_byte(nv_opt), .nonvolatile_protection_byte(nv_prot),
    .backdoor_key_bytes(key), .flash_write(flash_write),
    .dbg_prot_valid(dbg_prot_valid), .dbg_prot_data(dbg_prot_data),
    .mem_req_unsecured(mem_req_unsecured), .stop_entry(stop_entry),
    .engine_done(engine_done), .engine_blank_ok(engine_blank_ok),
    .mem_access_blocked(mem_access_blocked),
    .vector_redirect_disable(vector_redirect_disable),
    .secure_state(secure_state), .cmd_start(cmd_start), .cmd_out(cmd_out),
    .divider_value(divider_value));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // The launch pulse lasts one cycle, so it is caught on every edge.
  always @(posedge hclk) begin
    cycles++;
    if (cmd_start === 1'b1) begin
      n_start++;
      last_cmd = cmd_out;
    end
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task chk_rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, ex}, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : chk_rd

  task fw(input logic [15:0] a, input logic [7:0] d, input logic dbg);
    @(posedge hclk);
    flash_write <= {1'b1, dbg, a, d};
    @(posedge hclk);
    flash_write <= '0;
  endtask : fw

  task keyseq(input logic dbg);
    bus(1'b1, `FOPS_OFS_CONFIG, 8'h20);
    for (int i = 0; i < `FOPS_KEY_BYTES; i++)
      fw(16'hffb0 + 16'(i), key[63 - 8 * i -: 8], dbg);
    bus(1'b1, `FOPS_OFS_CONFIG, 8'h00);
    repeat (3) @(posedge hclk);
  endtask : keyseq

  task launch(input logic [15:0] a, input logic [7:0] code);
    s0 = n_start;
    fw(a, 8'h5a, 1'b0);
    bus(1'b1, `FOPS_OFS_COMMAND, code);
    bus(1'b1, `FOPS_OFS_STATUS, 8'h80);
    repeat (4) @(posedge hclk);
  endtask : launch

  task engine(input logic ok);
    @(posedge hclk);
    engine_done <= 1'b1;
    engine_blank_ok <= ok;
    @(posedge hclk);
    engine_done <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : engine

  task do_reset(input logic [7:0] o, input logic [7:0] p);
    @(posedge hclk);
    hresetn <= 1'b0;
    nv_opt <= o;
    nv_prot <= p;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : do_reset

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b000;
    hwdata = 32'h0;
    nv_opt = 8'h00;
    nv_prot = 8'h00;
    key = 64'h0123456789abcdef;
    flash_write = '0;
    dbg_prot_valid = 1'b0;
    dbg_prot_data = 8'h00;
    mem_req_unsecured = 1'b1;
    stop_entry = 1'b0;
    engine_done = 1'b0;
    engine_blank_ok = 1'b0;
    codes = '{`FOPS_CMD_BLANK, `FOPS_CMD_BYTE_PROG, `FOPS_CMD_BURST_PROG,
              `FOPS_CMD_PAGE_ERASE, `FOPS_CMD_MASS_ERASE};
    // Every security code, with the unused option bits set in flash.
    for (int c = 0; c < 4; c++) begin
      do_reset({2'b01, 4'hf, 2'(c)}, 8'hff);
      chk_rd("option", `FOPS_OFS_OPTION, {2'b01, 4'h0, 2'(c)});
      bus(1'b1, `FOPS_OFS_OPTION, 8'hff);
      chk_rd("option", `FOPS_OFS_OPTION, {2'b01, 4'h0, 2'(c)});
      `CHK("redirect", 1'b1, vector_redirect_disable)
      `CHK("secure", 1'(c != 2), secure_state)
      `CHK("blocked", 1'(c != 2), mem_access_blocked)
      if (c == 0) begin
        keyseq(1'b0);
        `CHK("secure", 1'b1, secure_state)
      end
    end
    do_reset(8'h83, 8'h80);
    `CHK("redirect", 1'b0, vector_redirect_disable)
    bus(1'b1, `FOPS_OFS_CONFIG, 8'hff);
    chk_rd("config", `FOPS_OFS_CONFIG, 8'he0);
    bus(1'b1, `FOPS_OFS_CONFIG, 8'h00);
    keyseq(1'b1);
    `CHK("secure", 1'b1, secure_state)
    keyseq(1'b0);
    `CHK("secure", 1'b0, secure_state)
    chk_rd("option", `FOPS_OFS_OPTION, 8'h82);
    chk_rd("protect", `FOPS_OFS_PROTECT, 8'h80);
    bus(1'b1, `FOPS_OFS_PROTECT, 8'ha0);
    chk_rd("protect", `FOPS_OFS_PROTECT, 8'h80);
    bus(1'b1, `FOPS_OFS_PROTECT, 8'h60);
    chk_rd("protect", `FOPS_OFS_PROTECT, 8'h60);
    bus(1'b1, `FOPS_OFS_DIVIDER, 8'h0c);
    launch(16'hfe00, `FOPS_CMD_BYTE_PROG);
    chk_rd("status", `FOPS_OFS_STATUS, 8'he0);
    `CHK("starts", s0, n_start)
    bus(1'b1, `FOPS_OFS_STATUS, 8'h20);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hc0);
    @(posedge hclk);
    dbg_prot_valid <= 1'b1;
    dbg_prot_data <= 8'hff;
    @(posedge hclk);
    dbg_prot_valid <= 1'b0;
    chk_rd("protect", `FOPS_OFS_PROTECT, 8'hff);
    bus(1'b1, `FOPS_OFS_PROTECT, 8'h10);
    chk_rd("protect", `FOPS_OFS_PROTECT, 8'hff);
    launch(16'hfe00, `FOPS_CMD_BYTE_PROG);
    `CHK("starts", s0 + 1, n_start)
    engine(1'b0);
    do_reset(8'h00, 8'h01);
    bus(1'b1, `FOPS_OFS_STATUS, 8'h0b);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hc0);
    chk_rd("divider", `FOPS_OFS_DIVIDER, 8'h00);
    launch(16'h0000, `FOPS_CMD_BYTE_PROG);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hd0);
    `CHK("starts", s0, n_start)
    bus(1'b1, `FOPS_OFS_STATUS, 8'h00);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hd0);
    bus(1'b1, `FOPS_OFS_STATUS, 8'h10);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hc0);
    bus(1'b1, `FOPS_OFS_DIVIDER, 8'h0c);
    chk_rd("divider", `FOPS_OFS_DIVIDER, 8'h8c);
    `CHK("divider value", 7'h0c, divider_value)
    launch(16'h0000, `FOPS_CMD_BLANK);
    `CHK("starts", s0 + 1, n_start)
    chk_rd("status", `FOPS_OFS_STATUS, 8'h80);
    engine(1'b1);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hc4);
    `CHK("secure", 1'b0, secure_state)
    launch(16'h0000, 8'h33);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hd4);
    bus(1'b1, `FOPS_OFS_STATUS, 8'h10);
    for (int k = 0; k < 5; k++) begin
      launch(16'h0000, codes[k]);
      `CHK("code", codes[k], last_cmd.code)
      `CHK("cmd addr", 16'h0000, last_cmd.addr)
      `CHK("cmd data", 8'h5a, last_cmd.data)
      engine(1'b0);
    end
    chk_rd("status", `FOPS_OFS_STATUS, 8'hc0);
    // Stop arrives while the engine still owns the command.
    launch(16'h0000, `FOPS_CMD_BYTE_PROG);
    @(posedge hclk);
    stop_entry <= 1'b1;
    @(posedge hclk);
    stop_entry <= 1'b0;
    repeat (2) @(posedge hclk);
    chk_rd("status", `FOPS_OFS_STATUS, 8'hd0);
    complete_run();
  end
endmodule : test_fops_ctrl
